//--- hw/dma_status_pkg.sv
package dma_status_pkg;

    localparam int          NUM_CHANNELS    = 8;
    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 16;

    // register offsets
    localparam logic [2:0]  COLLISION_OFF   = 3'h0;
    localparam logic [2:0]  ACTIVITY_OFF    = 3'h1;
    localparam logic [2:0]  RECENT_ADDR_OFF = 3'h2;
    localparam logic [2:0]  INT_STATUS_OFF  = 3'h3;
    localparam logic [2:0]  INT_MASK_OFF    = 3'h4;
    localparam logic [2:0]  MODE_OFF        = 3'h5;

    // field positions
    localparam int          PERIPH_COL_LSB  = 8;
    localparam int          RAM_COL_LSB     = 0;
    localparam int          LAST_CH_LSB     = 8;
    localparam int          PINGPONG_LSB    = 0;

    // reset values
    localparam logic [3:0]  LAST_CH_NONE    = 4'hf;
    localparam logic [15:0] COLLISION_RST   = 16'h0000;
    localparam logic [7:0]  PINGPONG_RST    = 8'h00;
    localparam logic [15:0] RECENT_ADDR_RST = 16'h0000;
    localparam logic [15:0] INT_MASK_RST    = 16'h0000;

    // interrupt status bits
    localparam int          INT_PCOL_BIT    = 0;
    localparam int          INT_RCOL_BIT    = 1;
    localparam int          INT_DONE_BIT    = 2;
    localparam int          INT_BITS        = 3;

    // two-bit operating mode encodings
    localparam logic [1:0]  MODE_CONT       = 2'h0;
    localparam logic [1:0]  MODE_ONESHOT    = 2'h1;
    localparam logic [1:0]  MODE_PP_CONT    = 2'h2;
    localparam logic [1:0]  MODE_PP_ONESHOT = 2'h3;

    typedef enum logic [1:0] {
        OP_CONT,
        OP_ONESHOT,
        OP_PP_CONT,
        OP_PP_ONESHOT
    } op_mode_e;

endpackage

//--- hw/chan_event_if.sv
interface chan_event_if #(parameter int N = 8);
    logic [N-1:0] periph_col;
    logic [N-1:0] ram_col;
    logic [N-1:0] block_done;
    logic [N-1:0] pp_enable;
    logic [N-1:0] clear_periph;
    logic [N-1:0] clear_ram;
    logic [N-1:0] periph_flag;
    logic [N-1:0] ram_flag;
    logic [N-1:0] pingpong;
    modport tracker (
        input  periph_col, ram_col, block_done, pp_enable, clear_periph, clear_ram,
        output periph_flag, ram_flag, pingpong
    );
    modport owner (
        output periph_col, ram_col, block_done, pp_enable, clear_periph, clear_ram,
        input  periph_flag, ram_flag, pingpong
    );
endinterface

//--- hw/chan_flags.sv
module chan_flags
    import dma_status_pkg::*;
#(
    parameter int N = NUM_CHANNELS
)
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    input  wire logic   clk_en,
    // per-channel events
    chan_event_if.tracker ev
);
    genvar ch;
    generate
        for (ch = 0; ch < N; ch++)
        begin : g_ch
            // set wins over a clear in the same cycle
            wire next_pcol = ev.periph_col[ch] | (ev.periph_flag[ch] & ~ev.clear_periph[ch]);
            wire next_rcol = ev.ram_col[ch] | (ev.ram_flag[ch] & ~ev.clear_ram[ch]);
            wire next_pp   = ev.pp_enable[ch] & ev.block_done[ch];

            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    ev.periph_flag[ch] <= 1'b0;
                    ev.ram_flag[ch]    <= 1'b0;
                    ev.pingpong[ch]    <= 1'b0;
                end
                else if (clk_en)
                begin
                    ev.periph_flag[ch] <= next_pcol;
                    ev.ram_flag[ch]    <= next_rcol;
                    if (next_pp)
                        ev.pingpong[ch] <= ~ev.pingpong[ch];
                end
            end

            pp_toggle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && ev.pp_enable[ch] && ev.block_done[ch]
                |=> ev.pingpong[ch] != $past(ev.pingpong[ch]))
                else $error("ping-pong flag did not toggle on block done");
            col_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && ev.periph_col[ch] |=> ev.periph_flag[ch])
                else $error("peripheral collision flag not set");
        end
    endgenerate
endmodule

//--- hw/dma_status_monitor.sv
module dma_status_monitor
    import dma_status_pkg::*;
#(
    parameter int N = NUM_CHANNELS
)
(
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    input  wire logic                        clk_en,
    // register port
    input  wire logic [dma_status_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [dma_status_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [dma_status_pkg::DATA_W-1:0] reg_rdata,
    // channel engine events
    input  wire logic [N-1:0]                periph_collision,
    input  wire logic [N-1:0]                ram_collision,
    input  wire logic [N-1:0]                xfer_done,
    input  wire logic [N-1:0]                block_done,
    input  wire logic                        ram_access,
    input  wire logic [15:0]                 ram_access_addr,
    // per-channel buffer select and interrupt
    output logic      [N-1:0]                use_secondary_buffer,
    output logic                             irq
);
    import dma_status_pkg::*;

    chan_event_if #(.N(N)) ev ();

    logic [3:0]          last_active_channel;
    logic [15:0]         recent_ram_address;
    logic [INT_BITS-1:0] int_status;
    logic [INT_BITS-1:0] int_mask;
    logic [2*N-1:0]      chan_mode;

    // register decode
    wire wr_collision = reg_wr && reg_addr == COLLISION_OFF;
    wire wr_int_stat  = reg_wr && reg_addr == INT_STATUS_OFF;
    wire wr_int_mask  = reg_wr && reg_addr == INT_MASK_OFF;
    wire wr_mode      = reg_wr && reg_addr == MODE_OFF;

    // zero written clears, one keeps
    assign ev.clear_periph = {N{wr_collision}} & ~reg_wdata[PERIPH_COL_LSB +: N];
    assign ev.clear_ram    = {N{wr_collision}} & ~reg_wdata[RAM_COL_LSB +: N];
    assign ev.periph_col   = periph_collision;
    assign ev.ram_col      = ram_collision;
    assign ev.block_done   = block_done;

    genvar ch;
    generate
        for (ch = 0; ch < N; ch++)
        begin : g_mode
            // only the two ping-pong encodings have bit 1 set
            assign ev.pp_enable[ch] = chan_mode[2*ch+1];
        end
    endgenerate

    chan_flags #(
        .N (N)
    ) chan_flags_i (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .ev      (ev)
    );

    assign use_secondary_buffer = ev.pingpong;

    // lowest-numbered completing channel wins when several finish together
    logic [3:0] done_channel;
    always_comb
    begin
        done_channel = LAST_CH_NONE;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (xfer_done[i])
                done_channel = 4'(i);
        end
    end
    wire any_done = |xfer_done;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            last_active_channel <= LAST_CH_NONE;
            recent_ram_address  <= RECENT_ADDR_RST;
        end
        else if (clk_en)
        begin
            if (any_done)
                last_active_channel <= done_channel;
            if (ram_access)
                recent_ram_address <= ram_access_addr;
        end
    end

    // interrupt events
    wire [INT_BITS-1:0] int_event = {any_done, |ram_collision, |periph_collision};
    wire [INT_BITS-1:0] next_int_status =
        int_event | (int_status & ~({INT_BITS{wr_int_stat}} & reg_wdata[INT_BITS-1:0]));

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            int_status <= '0;
            int_mask   <= INT_MASK_RST[INT_BITS-1:0];
            chan_mode  <= '0;
        end
        else if (clk_en)
        begin
            int_status <= next_int_status;
            if (wr_int_mask)
                int_mask <= reg_wdata[INT_BITS-1:0];
            if (wr_mode)
                chan_mode <= reg_wdata[2*N-1:0];
        end
    end

    assign irq = |(int_status & int_mask);

    // read mux
    logic [DATA_W-1:0] read_value;
    always_comb
    begin
        read_value = '0;
        case (reg_addr)
            COLLISION_OFF:
                read_value = {ev.periph_flag, ev.ram_flag};
            ACTIVITY_OFF:
                read_value = {4'h0, last_active_channel, ev.pingpong};
            RECENT_ADDR_OFF:
                read_value = recent_ram_address;
            INT_STATUS_OFF:
                read_value = {{(DATA_W-INT_BITS){1'b0}}, int_status};
            INT_MASK_OFF:
                read_value = {{(DATA_W-INT_BITS){1'b0}}, int_mask};
            MODE_OFF:
                read_value = chan_mode;
            default:
                read_value = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= '0;
        else if (clk_en)
            reg_rdata <= reg_rd ? read_value : '0;
    end

    last_chan_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && xfer_done[0] |=> last_active_channel == 4'h0)
        else $error("last channel not loaded");
    no_reserved_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        last_active_channel <= 4'h7 || last_active_channel == 4'hf)
        else $error("reserved last channel code");
    recent_addr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && ram_access |=> recent_ram_address == $past(ram_access_addr))
        else $error("recent address not captured");
    top_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && reg_rd && reg_addr == ACTIVITY_OFF |=> reg_rdata[15:12] == 4'h0)
        else $error("unimplemented bits read nonzero");
    clear_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && wr_collision && reg_wdata[8] && ev.periph_flag[0] |=> ev.periph_flag[0])
        else $error("writing one cleared a collision flag");
    clear_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && wr_collision && !reg_wdata[0] && !ram_collision[0] |=> !ev.ram_flag[0])
        else $error("writing zero did not clear");
    pp_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && !chan_mode[1] |=> $stable(ev.pingpong[0]))
        else $error("ping-pong flag moved outside ping-pong mode");
    irq_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && int_mask[INT_PCOL_BIT] && |periph_collision |=> irq)
        else $error("unmasked collision raised no interrupt");
    ram_col_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && ram_collision[3] |=> ev.ram_flag[3])
        else $error("ram collision flag not set");
    last_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && !any_done |=> $stable(last_active_channel))
        else $error("last channel moved without a transfer");
    last_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && any_done |=> last_active_channel <= 4'h7)
        else $error("transfer left no channel number");
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data stood beyond its cycle");
    freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !clk_en |=> $stable(reg_rdata) && $stable(last_active_channel)
            && $stable(recent_ram_address) && $stable(int_status))
        else $error("state moved while clock enable was low");
    int_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && |ram_collision |=> int_status[INT_RCOL_BIT])
        else $error("ram collision did not set interrupt status");
    int_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && wr_int_stat && reg_wdata[INT_DONE_BIT] && !any_done
        |=> !int_status[INT_DONE_BIT])
        else $error("writing one did not clear interrupt status");

    // per-channel flag behaviour
    generate
        for (ch = 0; ch < N; ch++)
        begin : g_chk
            pcol_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && !periph_collision[ch] && !ev.clear_periph[ch]
                |=> ev.periph_flag[ch] == $past(ev.periph_flag[ch]))
                else $error("peripheral collision flag not sticky");
            rcol_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && !ram_collision[ch] && !ev.clear_ram[ch]
                |=> ev.ram_flag[ch] == $past(ev.ram_flag[ch]))
                else $error("ram collision flag not sticky");
            pcol_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && ev.clear_periph[ch] && !periph_collision[ch]
                |=> !ev.periph_flag[ch])
                else $error("peripheral collision flag not cleared");
            rcol_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && ram_collision[ch] |=> ev.ram_flag[ch])
                else $error("ram collision flag not set");
            pp_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                clk_en && !(ev.pp_enable[ch] && block_done[ch])
                |=> $stable(ev.pingpong[ch]))
                else $error("ping-pong flag moved without a ping-pong block");
            chan_freeze_a: assert property (@(posedge sys_clk) disable iff (!resetn)
                !clk_en |=> $stable(ev.periph_flag[ch]) && $stable(ev.ram_flag[ch])
                    && $stable(ev.pingpong[ch]))
                else $error("channel flags moved while clock enable was low");
        end
    endgenerate
endmodule

//--- verification/dma_status_monitor_tb.sv
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module dma_status_monitor_tb;
    import dma_status_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        clk_en  = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [7:0]  periph_collision = 8'h00;
    logic [7:0]  ram_collision = 8'h00;
    logic [7:0]  xfer_done = 8'h00;
    logic [7:0]  block_done = 8'h00;
    logic        ram_access = 1'b0;
    logic [15:0] ram_access_addr = 16'h0000;
    logic [7:0]  use_secondary_buffer;
    logic        irq;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    dma_status_monitor dma_status_monitor_i (
        .sys_clk              (sys_clk),
        .resetn               (resetn),
        .clk_en               (clk_en),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .periph_collision     (periph_collision),
        .ram_collision        (ram_collision),
        .xfer_done            (xfer_done),
        .block_done           (block_done),
        .ram_access           (ram_access),
        .ram_access_addr      (ram_access_addr),
        .use_secondary_buffer (use_secondary_buffer),
        .irq                  (irq)
    );

    task automatic test_done();
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard: the whole sequence needs about 130 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // one-cycle event pulse on the chosen engine input
    task automatic pulse(input logic [1:0] k, input logic [7:0] v);
        @(posedge sys_clk);
        case (k)
            2'h0: periph_collision <= v;
            2'h1: ram_collision <= v;
            2'h2: xfer_done <= v;
            default: block_done <= v;
        endcase
        @(posedge sys_clk);
        periph_collision <= 8'h00;
        ram_collision <= 8'h00;
        xfer_done <= 8'h00;
        block_done <= 8'h00;
        #1;
    endtask

    task automatic reset_values();
        logic [15:0] d;
        rd(COLLISION_OFF, d);   `CHK(d, 16'h0000)
        rd(ACTIVITY_OFF, d);    `CHK(d, 16'h0f00)
        rd(RECENT_ADDR_OFF, d); `CHK(d, 16'h0000)
        rd(3'h7, d);            `CHK(d, 16'h0000)
        `CHK(use_secondary_buffer, 8'h00)
        `CHK(irq, 1'b0)
    endtask

    task automatic collisions();
        logic [15:0] d;
        pulse(2'h0, 8'h80);
        `CHK(irq, 1'b0)
        pulse(2'h1, 8'h01);
        rd(COLLISION_OFF, d);   `CHK(d, 16'h8001)
        rd(INT_STATUS_OFF, d);  `CHK(d, 16'h0003)
        wr(INT_MASK_OFF, 16'h0003);
        #1 `CHK(irq, 1'b1)
        wr(COLLISION_OFF, 16'hffff);
        rd(COLLISION_OFF, d);   `CHK(d, 16'h8001)
        wr(COLLISION_OFF, 16'h7ffe);
        rd(COLLISION_OFF, d);   `CHK(d, 16'h0000)
        rd(INT_MASK_OFF, d);    `CHK(d, 16'h0003)
        // a clear and a new collision in one cycle: the collision wins
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= COLLISION_OFF;
        reg_wdata <= 16'h0000;
        periph_collision <= 8'h02;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        periph_collision <= 8'h00;
        rd(COLLISION_OFF, d);   `CHK(d, 16'h0200)
        wr(COLLISION_OFF, 16'h0000);
        rd(COLLISION_OFF, d);   `CHK(d, 16'h0000)
        wr(INT_STATUS_OFF, 16'h0003);
        #1 `CHK(irq, 1'b0)
    endtask

    task automatic last_channel();
        logic [15:0] d;
        for (int ch = 7; ch >= 0; ch--)
        begin
            pulse(2'h2, 8'h01 << ch);
            rd(ACTIVITY_OFF, d);
            `CHK(d[11:8], ch[3:0])
        end
        pulse(2'h2, 8'hc0);
        rd(ACTIVITY_OFF, d);    `CHK(d, 16'h0600)
    endtask

    task automatic ping_pong();
        logic [15:0] d;
        // ch0 continuous ping-pong, ch1 one-shot ping-pong, ch2 plain, ch3 one-shot
        wr(MODE_OFF, 16'h004e);
        rd(MODE_OFF, d);        `CHK(d, 16'h004e)
        pulse(2'h3, 8'h0f);
        `CHK(use_secondary_buffer, 8'h03)
        rd(ACTIVITY_OFF, d);    `CHK(d[7:0], 8'h03)
        wr(ACTIVITY_OFF, 16'hffff);
        rd(ACTIVITY_OFF, d);    `CHK(d, 16'h0603)
        pulse(2'h3, 8'h02);
        `CHK(use_secondary_buffer, 8'h01)
    endtask

    task automatic recent_address();
        logic [15:0] d;
        @(posedge sys_clk);
        ram_access <= 1'b1;
        ram_access_addr <= 16'hbeef;
        @(posedge sys_clk);
        ram_access_addr <= 16'h1234;
        @(posedge sys_clk);
        ram_access <= 1'b0;
        wr(RECENT_ADDR_OFF, 16'h0000);
        rd(RECENT_ADDR_OFF, d); `CHK(d, 16'h1234)
    endtask

    // low clock enable: events pass without trace
    task automatic freeze();
        logic [15:0] d;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        pulse(2'h0, 8'h01);
        pulse(2'h2, 8'h01);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(COLLISION_OFF, d);   `CHK(d, 16'h0000)
        rd(ACTIVITY_OFF, d);    `CHK(d, 16'h0601)
        rd(INT_STATUS_OFF, d);  `CHK(d, 16'h0004)
        @(posedge sys_clk);
        #1 `CHK(reg_rdata, 16'h0000)
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        reset_values();
        collisions();
        last_channel();
        ping_pong();
        recent_address();
        freeze();
        test_done();
    end
endmodule
